/* File: hdl/pll_cfg_pkg.sv */
// Package with the PLL default configuration word layout, register map and decode constants.
package pll_cfg_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Register map (word offsets on the plain register port).
  localparam logic [3:0] OFS_CFG_WORD = 4'h0;
  localparam logic [3:0] OFS_PROG_CTRL = 4'h4;
  localparam logic [3:0] OFS_DECODE = 4'h8;

  // Field positions within the configuration word.
  localparam int ODIV_LSB = 16;
  localparam int USB_DIS_BIT = 15;
  localparam int UIDIV_LSB = 8;
  localparam int MUL_LSB = 4;
  localparam int IDIV_LSB = 0;
  localparam int FIELD_W = 3;

  // Reserved bits must be programmed as one; this mask marks them.
  localparam logic [31:0] RSVD_MASK = 32'hfff8_7888;

  // Erased value of the word, with every bit set.
  localparam logic [31:0] CFG_ERASED = 32'hffff_ffff;

  // Programming control: key value that opens one programming write.
  localparam logic [31:0] PROG_KEY = 32'h0000_a5c3;

  // Number of divide and multiply codes.
  localparam int NCODES = 8;

  // Programming sequencer states, Gray coded.
  typedef enum logic [1:0] {
    ST_LOCKED = 2'b00,
    ST_ARMED = 2'b01,
    ST_DONE = 2'b11
  } prog_state_e;

endpackage

/* File: hdl/pll_field_decode.sv */
// Decoder turning the three-bit PLL output divide, multiply and USB input divide fields into ratios.
`timescale 1ns/1ps
module pll_field_decode
  import pll_cfg_pkg::*;
(
  input wire logic [2:0] odiv_code_in,
  input wire logic [2:0] mul_code_in,
  input wire logic [2:0] uidiv_code_in,
  output logic [8:0] odiv_ratio_out,
  output logic [4:0] mul_ratio_out,
  output logic [3:0] uidiv_ratio_out
);

  // Constant lookup tables indexed by the field code.
  localparam logic [8:0] ODIV_TAB [NCODES] = '{9'h001, 9'h002, 9'h004, 9'h008,
                                              9'h010, 9'h020, 9'h040, 9'h100};
  localparam logic [4:0] MUL_TAB [NCODES] = '{5'h0f, 5'h10, 5'h11, 5'h12,
                                             5'h13, 5'h14, 5'h15, 5'h18};
  localparam logic [3:0] UIDIV_TAB [NCODES] = '{4'h1, 4'h2, 4'h3, 4'h4,
                                               4'h5, 4'h6, 4'ha, 4'hc};

  // Table selection of each ratio.
  assign odiv_ratio_out = ODIV_TAB[odiv_code_in];
  assign mul_ratio_out = MUL_TAB[mul_code_in];
  assign uidiv_ratio_out = UIDIV_TAB[uidiv_code_in];

endmodule

/* File: hdl/pll_default_config_word.sv */
// Nonvolatile PLL default configuration word with readback and decoded PLL settings.
//
// Behaviour
// - Bits 18-16 select PLL output divide 1,2,4,8,16,32,64 or 256.
// - Bit 15 high disables and bypasses the USB PLL; low enables it.
// - Bits 10-8 select USB PLL input divide 1,2,3,4,5,6,10 or 12.
// - Bits 6-4 select PLL multiply 15 through 21, or 24.
// - All fields read back; only programming changes them, not run-time writes.
// - USB PLL bits act only on variants that include USB.
`timescale 1ns/1ps
module pll_default_config_word
  import pll_cfg_pkg::*;
#(
  parameter bit HAS_USB = 1'b1
)
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic [2:0] pll_out_divisor_out,
  output logic [8:0] pll_out_ratio_out,
  output logic [2:0] pll_multiplier_out,
  output logic [4:0] pll_mul_ratio_out,
  output logic [2:0] pll_in_divider_out,
  output logic usb_pll_disable_out,
  output logic [2:0] usb_pll_in_divider_out,
  output logic [3:0] usb_in_ratio_out,
  output logic rsvd_error_out
);

  // The store has no reset: it powers up erased and keeps its word across resets.
  logic [31:0] nv_word_q = CFG_ERASED;
  logic [31:0] act_word_q;
  logic [31:0] rdata_q;
  logic rsvd_err_q;
  prog_state_e state_q;
  logic [8:0] odiv_ratio;
  logic [4:0] mul_ratio;
  logic [3:0] uidiv_ratio;

  // Address and strobe decode.
  wire sel_cfg = (addr_in == OFS_CFG_WORD);
  wire sel_prog = (addr_in == OFS_PROG_CTRL);
  wire sel_dec = (addr_in == OFS_DECODE);
  wire key_wr = wr_in && sel_prog && (wdata_in == PROG_KEY);
  wire prog_wr = wr_in && sel_cfg && (state_q == ST_ARMED);
  wire rsvd_bad = (wdata_in & RSVD_MASK) != RSVD_MASK;

  // Programming sequencer: a key write arms one word write, then it locks until reset.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_LOCKED;
    end else begin
      case (state_q)
        ST_LOCKED: begin
          if (key_wr) begin
            state_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (prog_wr) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_DONE;
        default: state_q <= ST_LOCKED;
      endcase
    end
  end

  // Nonvolatile store; programming can only clear bits, like erased flash.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rsvd_err_q <= 1'b0;
    end else if (prog_wr) begin
      rsvd_err_q <= rsvd_bad;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (prog_wr) begin
      nv_word_q <= nv_word_q & wdata_in;
    end
  end

  // The active settings are latched from the store only after device reset, on the first edge in ST_LOCKED without a key write.
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act_word_q <= CFG_ERASED;
    end else if (state_q == ST_LOCKED && !key_wr && act_word_q == CFG_ERASED) begin
      act_word_q <= nv_word_q;
    end
  end

  // Field extraction for the PLL.
  assign pll_out_divisor_out = act_word_q[ODIV_LSB +: FIELD_W];
  assign pll_multiplier_out = act_word_q[MUL_LSB +: FIELD_W];
  assign pll_in_divider_out = act_word_q[IDIV_LSB +: FIELD_W];
  assign usb_pll_disable_out = HAS_USB ? act_word_q[USB_DIS_BIT] : 1'b1;
  assign usb_pll_in_divider_out = HAS_USB ? act_word_q[UIDIV_LSB +: FIELD_W] : 3'h0;
  assign rsvd_error_out = rsvd_err_q;

  pll_field_decode u_dec (
    .odiv_code_in(pll_out_divisor_out),
    .mul_code_in(pll_multiplier_out),
    .uidiv_code_in(usb_pll_in_divider_out),
    .odiv_ratio_out(odiv_ratio),
    .mul_ratio_out(mul_ratio),
    .uidiv_ratio_out(uidiv_ratio)
  );

  assign pll_out_ratio_out = odiv_ratio;
  assign pll_mul_ratio_out = mul_ratio;
  assign usb_in_ratio_out = uidiv_ratio;

  // Read mux; unmapped addresses read zero.
  wire [31:0] prog_stat = {29'h0, rsvd_err_q, state_q};
  wire [31:0] dec_word = {14'h0, odiv_ratio, mul_ratio, uidiv_ratio};
  wire [31:0] rd_mux = sel_cfg ? nv_word_q :
                       sel_prog ? prog_stat :
                       sel_dec ? dec_word : 32'h0;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_q <= 32'h0;
    end else if (rd_in) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign rdata_out = rdata_q;

  // Steps of a programming pass: the key write arms, the next word write programs.
  sequence s_key_accepted;
    (state_q == ST_LOCKED) && key_wr;
  endsequence

  sequence s_word_programmed;
    (state_q == ST_ARMED) && wr_in && sel_cfg;
  endsequence

  // A run-time write without the key never alters the stored word.
  a_word_locked: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (wr_in && sel_cfg && state_q != ST_ARMED) |=> $stable(nv_word_q))
    else $error("config word changed without programming");

  // The key write arms the sequencer on the next edge.
  a_key_arms: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    s_key_accepted |=> (state_q == ST_ARMED))
    else $error("key write did not arm programming");

  // A programming write only clears stored bits.
  a_prog_clears: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    s_word_programmed |=> (nv_word_q == ($past(nv_word_q) & $past(wdata_in))))
    else $error("programming write stored a wrong word");

  // The reserved flag reports a programmed word with a reserved bit left at zero.
  a_rsvd_flag: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    s_word_programmed |=> (rsvd_error_out == (($past(wdata_in) & RSVD_MASK) != RSVD_MASK)))
    else $error("reserved flag wrong");

  // After programming the sequencer stays in ST_DONE for the next three cycles.
  a_prog_once: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    prog_wr |=> (state_q == ST_DONE) [*3])
    else $error("programming reopened");

  // Read data follow the read strobe by one cycle.
  a_read_back: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (rd_in && sel_cfg) |=> rdata_out == $past(nv_word_q))
    else $error("config word readback wrong");

  // Without a read strobe the read data fall back to zero.
  a_read_idle: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (!rd_in) |=> (rdata_out == 32'h0))
    else $error("read data not cleared");

  // Unmapped addresses read zero.
  a_read_unmapped: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (rd_in && !sel_cfg && !sel_prog && !sel_dec) |=> (rdata_out == 32'h0))
    else $error("unmapped read not zero");

  // Output divisor code 7 means divide by 256.
  a_odiv_max: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (pll_out_divisor_out == 3'h7) |-> pll_out_ratio_out == 9'h100)
    else $error("output divisor decode wrong");

  // Output divisor code 0 means no division.
  a_odiv_min: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (pll_out_divisor_out == 3'h0) |-> pll_out_ratio_out == 9'h001)
    else $error("output divisor base decode wrong");

  // Multiplier code 7 means 24 times.
  a_mul_top: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (pll_multiplier_out == 3'h7) |-> pll_mul_ratio_out == 5'h18)
    else $error("multiplier decode wrong");

  // Multiplier code 0 means 15 times.
  a_mul_base: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (pll_multiplier_out == 3'h0) |-> pll_mul_ratio_out == 5'h0f)
    else $error("multiplier base decode wrong");

  // USB input divider code 6 means divide by 10.
  a_usb_div: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (usb_pll_in_divider_out == 3'h6) |-> usb_in_ratio_out == 4'ha)
    else $error("usb divider decode wrong");

  // An enabled USB PLL needs a USB variant and a cleared bypass bit in the store.
  a_usb_bypass: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (!usb_pll_disable_out) |-> (HAS_USB && !nv_word_q[USB_DIS_BIT]))
    else $error("usb pll enabled without cleared bit");

  // The input divider code moves only when the erased active word reloads after reset.
  a_in_div: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    !$stable(pll_in_divider_out) |-> (($past(state_q) == ST_LOCKED)
      && ($past(act_word_q) == CFG_ERASED)))
    else $error("input divider moved");

endmodule

/* File: bench/testbench.sv */
// Self-checking testbench for the PLL default configuration word block.
`timescale 1ns/1ps
module testbench;
  import pll_cfg_pkg::*;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = 4'h0;
  logic [DATA_W-1:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rd_a, rd_b, exp_w;
  logic [2:0] od_a, od_b, mu_a, mu_b, id_a, id_b, ud_a, ud_b;
  logic [8:0] or_a, or_b;
  logic [4:0] mr_a, mr_b;
  logic [3:0] ur_a, ur_b;
  logic dis_a, dis_b, re_a, re_b;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int otab[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
  int mtab[8] = '{15, 16, 17, 18, 19, 20, 21, 24};
  int utab[8] = '{1, 2, 3, 4, 5, 6, 10, 12};

  // USB variant under test, and a variant without USB sharing the same bus.
  pll_default_config_word #(.HAS_USB(1'b1)) dut_u (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rd_a), .pll_out_divisor_out(od_a), .pll_out_ratio_out(or_a),
    .pll_multiplier_out(mu_a), .pll_mul_ratio_out(mr_a), .pll_in_divider_out(id_a),
    .usb_pll_disable_out(dis_a), .usb_pll_in_divider_out(ud_a), .usb_in_ratio_out(ur_a),
    .rsvd_error_out(re_a));
  pll_default_config_word #(.HAS_USB(1'b0)) dut_b (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rd_b), .pll_out_divisor_out(od_b), .pll_out_ratio_out(or_b),
    .pll_multiplier_out(mu_b), .pll_mul_ratio_out(mr_b), .pll_in_divider_out(id_b),
    .usb_pll_disable_out(dis_b), .usb_pll_in_divider_out(ud_b), .usb_in_ratio_out(ur_b),
    .rsvd_error_out(re_b));

  // Clock and hang guard.
  initial begin
    forever #50 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask

  // Read: data stands only in the cycle after the strobe, zero after that.
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 check(rd_a, e);
    @(posedge core_clk_in);
    #1 check(rd_a, 32'h0);
    @(posedge core_clk_in);
  endtask

  task automatic pulse_reset();
    resetn_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
  endtask

  // Compares the USB variant's decoded outputs, the other variant's except mu_b and id_b, and the USB readback with the expected word.
  task automatic check_fields(input logic [31:0] e);
    check(32'(od_a), 32'(e[18:16]));
    check(32'(or_a), 32'(otab[e[18:16]]));
    check(32'(dis_a), 32'(e[15]));
    check(32'(ud_a), 32'(e[10:8]));
    check(32'(ur_a), 32'(utab[e[10:8]]));
    check(32'(mu_a), 32'(e[6:4]));
    check(32'(mr_a), 32'(mtab[e[6:4]]));
    check(32'(id_a), 32'(e[2:0]));
    check(32'({dis_b, ud_b, od_b}), 32'({1'b1, 3'h0, e[18:16]}));
    check(32'({ur_b, or_b, mr_b}), 32'({4'h1, 9'(otab[e[18:16]]), 5'(mtab[e[6:4]])}));
    rd_chk(OFS_CFG_WORD, e);
    rd_chk(OFS_DECODE, 32'({9'(otab[e[18:16]]), 5'(mtab[e[6:4]]), 4'(utab[e[10:8]])}));
  endtask

  // Programs one word, checks the lock and reserved flag, then resets to apply it.
  task automatic prog(input logic [31:0] w);
    wr(OFS_PROG_CTRL, PROG_KEY);
    rd_chk(OFS_PROG_CTRL, 32'h1);
    wr(OFS_CFG_WORD, w);
    exp_w = exp_w & w;
    rd_chk(OFS_PROG_CTRL, {29'h0, (w & RSVD_MASK) != RSVD_MASK, 2'h3});
    check(32'(re_a), 32'((w & RSVD_MASK) != RSVD_MASK));
    wr(OFS_CFG_WORD, 32'h0);
    pulse_reset();
    check_fields(exp_w);
  endtask

  // Erased defaults, a refused write without the key and an unmapped read.
  task automatic erased_defaults();
    check_fields(CFG_ERASED);
    rd_chk(OFS_PROG_CTRL, 32'h0);
    wr(OFS_CFG_WORD, 32'h0);
    rd_chk(OFS_CFG_WORD, CFG_ERASED);
    rd_chk(4'hc, 32'h0);
  endtask

  // Main sequence: erased defaults, refused write, then three programming passes.
  initial begin
    exp_w = CFG_ERASED;
    repeat (20) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    erased_defaults();
    prog(RSVD_MASK | 32'h0006_0636);
    prog(RSVD_MASK | 32'h0004_0412);
    prog(32'hfff8_7880);
    print_verdict();
  end
endmodule
